// *** rtl/coproc_defines.svh ***
// offsets, field positions, reset values and counts of the coprocessor pair
// assumes inclusion by bare name from the modules
`ifndef COPROC_DEFINES_SVH
`define COPROC_DEFINES_SVH

// control and status word layout
`define CW_RESET      16'h03FF
`define CW_IEM        7
`define EXC_INVALID   0
`define EXC_ALL       6'h3F
`define EXT_BIAS      16383
// memory image: 94 bytes save area, 14 bytes environment, 16-bit words
`define SAVE_WORDS    6'd47
`define ENV_WORDS     6'd7
`define STK_FIRST     6'd7
`define STK_LAST_PC   3'd4
// numeric unit run length in sys_clk cycles
`define NEU_CYCLES    4'd8
// fixed point one in q16
`define ONE_Q16       48'h0000_0001_0000
// constants at extended precision, 64-bit significand
`define K_ZERO        80'h0000_0000_0000_0000_0000
`define K_ONE         80'h3FFF_8000_0000_0000_0000
`define K_PI          80'h4000_C90F_DAA2_2168_C235
`define K_L2T         80'h4000_D49A_784B_CD1B_8AFE
`define K_L2E         80'h3FFF_B8AA_3B29_5C17_F0BC
`define K_LG2         80'h3FFD_9A20_9A84_FBCF_F799
`define K_LN2         80'h3FFE_B172_17F7_D1CF_79AC
// cpu end register map, byte addresses
`define HOST_CMD      11'h000
`define HOST_STAT     11'h004
`define HOST_MEM_BIT  10
`define CMD_WAIT_BIT  8
`define CMD_BASE_LSB  16

`endif

// *** rtl/coproc_pkg.sv ***
// types shared by both ends of the coprocessor link
// assumes coproc_defines.svh beside it
package coproc_pkg;

  // extended real: sign, 15-bit exponent, 64-bit significand
  typedef logic [79:0] ext_t;

  // operation codes on the shared instruction stream
  typedef enum logic [4:0] {
    no_op,
    scaled_log2_op,
    scaled_log2_plus_one_op,
    push_zero_op,
    push_one_op,
    push_pi_op,
    push_log2_ten_op,
    push_log2_e_op,
    push_log10_two_op,
    push_ln_two_op,
    reinitialize_op,
    irq_mask_set_op,
    irq_mask_clear_op,
    control_word_load_op,
    control_word_store_op,
    status_word_store_op,
    exception_clear_op,
    full_state_save_op,
    full_state_restore_op,
    environment_store_op,
    cpu_sync_wait
  } op_e;

endpackage

// *** rtl/coproc_if.sv ***
// link between cpu end and coprocessor end
// assumes both ends on one sys_clk; testbench binds instances
`timescale 1ns/1ps

interface coproc_if;
  import coproc_pkg::*;

  // operation issue
  logic        op_valid;
  op_e         op_code;
  logic [7:0]  op_base;
  logic        op_ready;
  // memory image transfers, one 16-bit word each
  logic        mem_req;
  logic        mem_we;
  logic [7:0]  mem_addr;
  logic [15:0] mem_wdata;
  logic        mem_ack;
  logic [15:0] mem_rdata;
  // status lines
  logic        busy;
  logic        irq;
  logic        idle;

  modport dev (
    input  op_valid, op_code, op_base, mem_ack, mem_rdata,
    output op_ready, mem_req, mem_we, mem_addr, mem_wdata, busy, irq, idle
  );
  modport cpu (
    output op_valid, op_code, op_base, mem_ack, mem_rdata,
    input  op_ready, mem_req, mem_we, mem_addr, mem_wdata, busy, irq, idle
  );
endinterface

// *** rtl/numeric_coprocessor.sv ***
// coprocessor end: control unit, numeric unit, memory image engine
// assumes a cpu end on coproc_if sharing sys_clk and rst_b
//
// Added by the designer: the Avalon-MM register port and the address map.
`timescale 1ns/1ps
`include "coproc_defines.svh"

// How it works
// - scaled log: y times log2 x, pop
// - plus-one variant uses x plus one
// - constants pushed with 64-bit significand
// - seven constant pushes, zero to ln two
// - control ops accepted while numeric unit busy
// - software picks waiting form when ordering matters
// - reinitialize equals reset, keeps stack contents and issue handshake
// - reinitialize aborts running memory transfers
// - mask set stops interrupt requests
// - mask clear allows interrupt requests
// - control load raises pending request at once
// - software clears exceptions before new modes
// - control and status word stores to memory
// - exception clear drops flags, irq, busy
// - handler clears exceptions before resuming
// - full save writes 94 bytes, then reinitializes
// - save queued behind running numeric op
// - cpu waits after no-wait save
// - restore reloads 94 bytes; wait before next
// - restore reacts at once to restored state
// - environment store writes control, status, tags, pointers
// - environment store then masks all exceptions
// - idle line releases the cpu wait
module numeric_coprocessor
  import coproc_pkg::*;
(
  input  wire logic sys_clk,
  input  wire logic rst_b,
  coproc_if.dev     bus
);

  typedef enum logic {eng_idle, eng_xfer} eng_e;

  typedef struct packed {
    ext_t [7:0]  st;
    logic [7:0]  full;
    logic [2:0]  top;
    logic [15:0] cw;
    logic [5:0]  exc;
    logic        busy;
    logic        neu_run;
    logic [3:0]  neu_cnt;
    op_e         neu_op;
    logic        pend;
    op_e         pend_op;
    logic [7:0]  pend_base;
    eng_e        eng;
    op_e         eng_op;
    logic [7:0]  eng_base;
    logic [5:0]  k;
    logic [5:0]  first;
    logic [5:0]  last;
    logic [2:0]  sr;
    logic [2:0]  sj;
    op_e         last_op;
    logic [7:0]  last_base;
    logic        op_ready;
    logic        mem_req;
    logic        mem_we;
    logic [7:0]  mem_addr;
    logic [15:0] mem_wdata;
    logic        irq;
    logic        idle;
  } dev_s;

  dev_s q;
  dev_s d;

  // reset state; stack contents and issue handshake survive
  function automatic dev_s reinit(dev_s s);
    dev_s r;
    r          = '0;
    r.st       = s.st;
    r.cw       = `CW_RESET;
    r.op_ready = s.op_ready;
    return r;
  endfunction

  function automatic logic [15:0] sw_word(dev_s s);
    return {s.busy, 1'b0, s.top, 3'h0, |(s.exc & ~s.cw[5:0]), 1'b0, s.exc};
  endfunction

  function automatic logic [15:0] tag_word(dev_s s);
    logic [15:0] t;
    t = 16'h0000;
    for (int i = 0; i < 8; i++) t[2*i +: 2] = s.full[i] ? 2'h0 : 2'h3;
    return t;
  endfunction

  // image word k: environment first, then stack pieces from top down
  function automatic logic [15:0] word_of(dev_s s);
    logic [15:0] w;
    unique case (s.k)
      6'h00:        w = s.cw;
      6'h01:        w = sw_word(s);
      6'h02:        w = tag_word(s);
      6'h03:        w = {11'h000, s.last_op};
      6'h04:        w = {8'h00, s.last_base};
      6'h05, 6'h06: w = 16'h0000;
      default:      w = 16'(s.st[3'(s.top + s.sr)] >> {s.sj, 4'h0});
    endcase
    return w;
  endfunction

  // restore: take word k back into state
  function automatic dev_s put_word(dev_s s, logic [15:0] w);
    logic [2:0] i;
    logic [6:0] sh;
    i  = 3'(s.top + s.sr);
    sh = {s.sj, 4'h0};
    unique case (s.k)
      6'h00: s.cw = w;
      6'h01: begin
        s.exc = w[5:0];
        s.top = w[13:11];
      end
      6'h02: for (int j = 0; j < 8; j++) s.full[j] = w[2*j +: 2] != 2'h3;
      6'h03, 6'h04, 6'h05, 6'h06: s.last_base = s.last_base;
      default: s.st[i] = (s.st[i] & ~(80'hFFFF << sh)) | (80'(w) << sh);
    endcase
    return s;
  endfunction

  function automatic dev_s eng_start(dev_s s, op_e op, logic [7:0] b);
    s.eng      = eng_xfer;
    s.eng_op   = op;
    s.eng_base = b;
    s.sr       = 3'h0;
    s.sj       = 3'h0;
    s.first    = 6'h00;
    s.mem_we   = !(op inside {control_word_load_op, full_state_restore_op});
    unique case (op)
      status_word_store_op: begin
        s.first = 6'h01;
        s.last  = 6'h01;
      end
      environment_store_op:  s.last = `ENV_WORDS - 6'h01;
      full_state_save_op,
      full_state_restore_op: s.last = `SAVE_WORDS - 6'h01;
      default:               s.last = 6'h00;
    endcase
    s.k = s.first;
    return s;
  endfunction

  // extended to signed q16; magnitudes of 2^31 and above clip
  function automatic logic signed [47:0] to_fix(ext_t v);
    int         sh;
    logic [63:0] m;
    sh = `EXT_BIAS + 47 - int'(v[78:64]);
    if (sh > 63) m = 64'h0;
    else if (sh < 17) m = 64'h0000_7FFF_FFFF_FFFF;
    else m = v[63:0] >> sh;
    return v[79] ? -$signed({1'b0, m[46:0]}) : $signed({1'b0, m[46:0]});
  endfunction

  function automatic ext_t from_fix(logic signed [47:0] v);
    logic [47:0] a;
    int          p;
    a = v[47] ? 48'(-v) : 48'(v);
    p = -1;
    for (int i = 0; i < 48; i++) if (a[i]) p = i;
    if (p < 0) return `K_ZERO;
    return {v[47], 15'(`EXT_BIAS + p - 16), 64'(a) << (63 - p)};
  endfunction

  // log2 of positive extended: exponent plus linear fraction, q16
  function automatic logic signed [47:0] log2_ext(ext_t v);
    return ($signed(48'(int'(v[78:64]) - `EXT_BIAS)) <<< 16) + $signed({32'h0, v[62:47]});
  endfunction

  function automatic logic signed [47:0] fmul(logic signed [47:0] a, logic signed [47:0] b);
    logic signed [95:0] p;
    p = a * b;
    return p[63:16];
  endfunction

  function automatic ext_t konst(op_e op);
    unique case (op)
      push_one_op:       return `K_ONE;
      push_pi_op:        return `K_PI;
      push_log2_ten_op:  return `K_L2T;
      push_log2_e_op:    return `K_L2E;
      push_log10_two_op: return `K_LG2;
      push_ln_two_op:    return `K_LN2;
      default:           return `K_ZERO;
    endcase
  endfunction

  // numeric op completion: scaled logs pop, constants push
  function automatic dev_s neu_done(dev_s s);
    logic [2:0] nx;
    ext_t       x;
    ext_t       a;
    nx = s.top + 3'h1;
    x  = s.st[s.top];
    if (s.neu_op inside {scaled_log2_op, scaled_log2_plus_one_op}) begin
      if (!s.full[s.top] || !s.full[nx] ||
          (s.neu_op == scaled_log2_op && (x[79] || x[78:64] == 15'h0))) begin
        s.exc[`EXC_INVALID] = 1'b1;
      end else begin
        a = (s.neu_op == scaled_log2_op) ? x : from_fix(to_fix(x) + `ONE_Q16);
        s.st[nx]      = from_fix(fmul(to_fix(s.st[nx]), log2_ext(a)));
        s.full[s.top] = 1'b0;
        s.top         = nx;
      end
    end else begin
      nx = s.top - 3'h1;
      if (s.full[nx]) begin
        s.exc[`EXC_INVALID] = 1'b1;
      end else begin
        s.st[nx]   = konst(s.neu_op);
        s.full[nx] = 1'b1;
        s.top      = nx;
      end
    end
    return s;
  endfunction

  // numeric ops need an idle unit; memory ops need the engine free
  function automatic logic can_take(dev_s s, op_e op);
    if (op inside {[scaled_log2_op:push_ln_two_op]})
      return !s.neu_run && !s.pend && s.eng == eng_idle;
    if (op inside {[control_word_load_op:status_word_store_op],
                   [full_state_save_op:environment_store_op]})
      return !s.pend && s.eng == eng_idle;
    return 1'b1;
  endfunction

  // next state of the whole coprocessor
  always_comb begin
    d          = q;
    d.op_ready = 1'b0;
    if (q.eng == eng_xfer && bus.mem_ack) begin
      if (!q.mem_we) d = put_word(d, bus.mem_rdata);
      if (q.k == q.last) begin
        d.eng = eng_idle;
        if (q.eng_op == full_state_save_op) d = reinit(d);
        else if (q.eng_op == environment_store_op) d.cw[5:0] = `EXC_ALL;
      end else begin
        if (q.k >= `STK_FIRST) begin
          d.sj = (q.sj == `STK_LAST_PC) ? 3'h0 : q.sj + 3'h1;
          d.sr = (q.sj == `STK_LAST_PC) ? q.sr + 3'h1 : q.sr;
        end
        d.k = q.k + 6'h01;
      end
    end
    if (q.neu_run) begin
      if (q.neu_cnt != 4'h0) begin
        d.neu_cnt = q.neu_cnt - 4'h1;
      end else begin
        d.neu_run = 1'b0;
        d.busy    = 1'b0;
        d         = neu_done(d);
      end
    end
    // queued save or environment store starts once the unit is done
    if (d.pend && !d.neu_run && d.eng == eng_idle) begin
      d      = eng_start(d, d.pend_op, d.pend_base);
      d.pend = 1'b0;
    end
    if (bus.op_valid && !q.op_ready && can_take(d, bus.op_code)) begin
      unique case (bus.op_code)
        reinitialize_op:    d = reinit(d);
        irq_mask_set_op:    d.cw[`CW_IEM] = 1'b1;
        irq_mask_clear_op:  d.cw[`CW_IEM] = 1'b0;
        exception_clear_op: begin
          d.exc  = d.exc & ~q.exc; // flag set this cycle wins
          d.busy = 1'b0;
        end
        control_word_load_op, control_word_store_op, status_word_store_op,
        full_state_restore_op:
          d = eng_start(d, bus.op_code, bus.op_base);
        full_state_save_op, environment_store_op: begin
          if (d.neu_run) begin
            d.pend      = 1'b1;
            d.pend_op   = bus.op_code;
            d.pend_base = bus.op_base;
          end else begin
            d = eng_start(d, bus.op_code, bus.op_base);
          end
        end
        default: begin
          if (bus.op_code inside {[scaled_log2_op:push_ln_two_op]}) begin
            d.neu_run   = 1'b1;
            d.neu_cnt   = `NEU_CYCLES - 4'h1;
            d.neu_op    = bus.op_code;
            d.busy      = 1'b1;
            d.last_op   = bus.op_code;
            d.last_base = bus.op_base;
          end
        end
      endcase
      d.op_ready = 1'b1;
    end
    // outputs registered from the next state
    d.mem_req   = d.eng == eng_xfer;
    d.mem_addr  = d.eng_base + 8'(d.k - d.first);
    d.mem_wdata = word_of(d);
    d.irq       = |(d.exc & ~d.cw[5:0]) & !d.cw[`CW_IEM];
    d.idle      = !d.neu_run && !d.pend && d.eng == eng_idle;
  end

  // single state register
  always_ff @(posedge sys_clk) begin
    if (!rst_b) q <= reinit(dev_s'(0));
    else q <= d;
  end

  assign bus.op_ready  = q.op_ready;
  assign bus.mem_req   = q.mem_req;
  assign bus.mem_we    = q.mem_we;
  assign bus.mem_addr  = q.mem_addr;
  assign bus.mem_wdata = q.mem_wdata;
  assign bus.busy      = q.busy;
  assign bus.irq       = q.irq;
  assign bus.idle      = q.idle;

endmodule

// *** rtl/cpu_end.sv ***
// cpu end: avalon-mm command port, issue with wait sync, image memory
// assumes numeric_coprocessor on the dev modport of the same coproc_if
`timescale 1ns/1ps
`include "coproc_defines.svh"

module cpu_end
  import coproc_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        rst_b,
  input  wire logic [10:0] address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [31:0] writedata,
  input  wire logic [3:0]  byteenable,
  output logic [31:0]      readdata,
  output logic             waitrequest,
  coproc_if.cpu            bus
);

  typedef struct packed {
    logic [255:0][15:0] mem;
    logic               cmd_pend;
    op_e                cmd_op;
    logic               cmd_wait;
    logic [7:0]         cmd_base;
    logic               need_wait;
    logic               op_valid;
    op_e                op_code;
    logic [7:0]         op_base;
    logic               mem_ack;
    logic [15:0]        mem_rdata;
    logic               waitrequest;
    logic [31:0]        readdata;
  } host_s;

  host_s q;
  host_s d;

  function automatic logic [31:0] rd(host_s s, logic [10:0] a);
    if (a[`HOST_MEM_BIT]) return {16'h0000, s.mem[a[9:2]]};
    if (a == `HOST_CMD)
      return {8'h00, s.cmd_base, 7'h00, s.cmd_wait, 3'h0, s.cmd_op};
    // pending also covers an issued op not yet taken, so idle polls cannot slip through
    if (a == `HOST_STAT)
      return {27'h0, s.need_wait, s.cmd_pend | s.op_valid, bus.idle, bus.irq, bus.busy};
    return 32'h0;
  endfunction

  always_comb begin
    logic hold;
    d    = q;
    hold = 1'b0;
    // image memory answers each device word one cycle later
    d.mem_ack = bus.mem_req && !q.mem_ack;
    if (d.mem_ack) begin
      if (bus.mem_we) d.mem[bus.mem_addr] = bus.mem_wdata;
      d.mem_rdata = q.mem[bus.mem_addr];
    end
    // issue, holding wait forms until the coprocessor is idle
    if (q.op_valid) begin
      if (bus.op_ready) d.op_valid = 1'b0;
    end else if (q.cmd_pend) begin
      hold = (q.cmd_wait || q.need_wait || q.cmd_op == cpu_sync_wait) && !bus.idle;
      if (!hold) begin
        d.cmd_pend  = 1'b0;
        d.need_wait = 1'b0;
        if (q.cmd_op != cpu_sync_wait) begin
          d.op_valid  = 1'b1;
          d.op_code   = q.cmd_op;
          d.op_base   = q.cmd_base;
          d.need_wait = q.cmd_op inside {full_state_save_op, full_state_restore_op,
                                         environment_store_op};
        end
      end
    end
    // avalon slave: decide, then answer with waitrequest low one cycle
    d.waitrequest = 1'b1;
    if (!q.waitrequest) begin
      if (write && address[`HOST_MEM_BIT] && &byteenable[1:0])
        d.mem[address[9:2]] = writedata[15:0];
      else if (write && address == `HOST_CMD && byteenable[0]) begin
        d.cmd_pend = 1'b1;
        d.cmd_op   = op_e'(writedata[4:0]);
        d.cmd_wait = writedata[`CMD_WAIT_BIT];
        d.cmd_base = writedata[`CMD_BASE_LSB +: 8];
      end
    end else if ((read || write) && !(write && address == `HOST_CMD && q.cmd_pend)) begin
      d.waitrequest = 1'b0;
      d.readdata    = read ? rd(q, address) : 32'h0;
    end
  end

  // single state register
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      q             <= '0;
      q.waitrequest <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign readdata      = q.readdata;
  assign waitrequest   = q.waitrequest;
  assign bus.op_valid  = q.op_valid;
  assign bus.op_code   = q.op_code;
  assign bus.op_base   = q.op_base;
  assign bus.mem_ack   = q.mem_ack;
  assign bus.mem_rdata = q.mem_rdata;

endmodule

// *** test/coproc_props.sv ***
// link checks between the cpu end and the coprocessor end
// assumes tb_top instantiates it beside the coproc_if it watches
`timescale 1ns/1ps

module coproc_props
  import coproc_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic op_valid,
  input wire op_e  op_code,
  input wire logic op_ready,
  input wire logic mem_req,
  input wire logic mem_ack,
  input wire logic busy,
  input wire logic irq,
  input wire logic idle
);
  // one clock domain, reset masks everything
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);

  // control ops answered next cycle whatever the numeric unit does
  AST_CTL_TAKEN: assert property (
    op_valid && !op_ready && op_code inside {reinitialize_op, irq_mask_set_op,
    irq_mask_clear_op, exception_clear_op} |=> op_ready) else $error("control op not taken");
  AST_NUM_BUSY: assert property (
    op_ready && op_code inside {[scaled_log2_op:push_ln_two_op]} |-> busy && !idle)
    else $error("numeric op taken without busy");
  AST_BUSY_BOUND: assert property ($rose(busy) |-> ##[1:9] !busy)
    else $error("busy held too long");
  AST_CLEAR: assert property (
    op_ready && op_code == exception_clear_op |-> ##[0:1] (!irq && !busy))
    else $error("exception clear left irq or busy");
  AST_MASK_SET: assert property (
    op_ready && op_code == irq_mask_set_op |-> ##2 !irq [*2]) else $error("irq while masked");
  AST_REINIT_ABORT: assert property (
    op_ready && op_code == reinitialize_op |-> ##[0:1] !mem_req) else $error("transfer kept");
  AST_ACK_NEXT: assert property (mem_req && !mem_ack |=> mem_ack)
    else $error("memory word not acknowledged");
  AST_ACK_PULSE: assert property (mem_ack |=> !mem_ack)
    else $error("ack longer than one cycle");
  AST_SAVE_QUEUED: assert property (
    op_ready && op_code == full_state_save_op && busy |-> !mem_req until !busy)
    else $error("save ran during numeric op");
  AST_WAIT_IDLE: assert property (
    (busy || mem_req) |-> !idle)
    else $error("idle shown while work runs");

  // main scenarios reached
  cover property (op_ready && op_code == full_state_save_op && busy);
  cover property ($rose(irq));
  cover property (op_ready && op_code == full_state_restore_op);
endmodule

// *** test/tb_top.sv ***
// testbench: both ends joined by coproc_if, driven over avalon-mm
// assumes package, interface and both ends compiled before it
`timescale 1ns/1ps
`include "coproc_defines.svh"

module tb_top
  import coproc_pkg::*;
;
  typedef struct {
    op_e         first;
    op_e         store;
    int          idx;
    int          n;
    logic [79:0] exp;
  } row_s;

  logic        sys_clk     = 1'b0;
  logic        rst_b       = 1'b0;
  logic [10:0] address     = 11'h000;
  logic        read        = 1'b0;
  logic        write       = 1'b0;
  logic [31:0] writedata   = 32'h0000_0000;
  logic [3:0]  byteenable  = 4'hF;
  logic [31:0] readdata;
  logic        waitrequest;
  logic [31:0] rd;
  logic [79:0] got;
  int          miscompares = 0;
  int          tests_run   = 0;
  logic [79:0] xv [2]      = '{80'h4001_8000_0000_0000_0000, `K_ONE};
  logic [79:0] yv [2]      = '{`K_ONE, 80'h4000_C000_0000_0000_0000};
  logic [79:0] zv [2]      = '{80'h4000_8000_0000_0000_0000, 80'h4000_C000_0000_0000_0000};
  row_s        rows [10]   = '{
    '{push_zero_op, full_state_save_op, 7, 5, `K_ZERO},
    '{push_one_op, full_state_save_op, 7, 5, `K_ONE},
    '{push_pi_op, full_state_save_op, 7, 5, `K_PI},
    '{push_log2_ten_op, full_state_save_op, 7, 5, `K_L2T},
    '{push_log2_e_op, full_state_save_op, 7, 5, `K_L2E},
    '{push_log10_two_op, full_state_save_op, 7, 5, `K_LG2},
    '{push_ln_two_op, full_state_save_op, 7, 5, `K_LN2},
    '{irq_mask_clear_op, control_word_store_op, 0, 1, 80'h037F},
    '{push_one_op, status_word_store_op, 0, 1, 80'h3800},
    '{no_op, environment_store_op, 2, 1, 80'hFFFF}
  };

  coproc_if link ();

  // 25 MHz clock
  always #20 sys_clk = ~sys_clk;

  numeric_coprocessor u_numeric_coprocessor (.sys_clk(sys_clk), .rst_b(rst_b), .bus(link.dev));
  cpu_end u_cpu_end (.sys_clk(sys_clk), .rst_b(rst_b), .address(address), .read(read),
    .write(write), .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
    .waitrequest(waitrequest), .bus(link.cpu));
  coproc_props u_coproc_props (.sys_clk(sys_clk), .rst_b(rst_b), .op_valid(link.op_valid),
    .op_code(link.op_code), .op_ready(link.op_ready), .mem_req(link.mem_req),
    .mem_ack(link.mem_ack), .busy(link.busy), .irq(link.irq), .idle(link.idle));

  // one avalon transfer, held until waitrequest is seen low
  task automatic xfer(input logic wr, input logic [10:0] a, input logic [31:0] d);
    int n = 0;
    @(posedge sys_clk);
    address <= a;
    writedata <= d;
    read <= !wr;
    write <= wr;
    do begin
      @(posedge sys_clk);
      n++;
    end while (waitrequest !== 1'b0 && n < 500);
    rd = readdata;
    read <= 1'b0;
    write <= 1'b0;
    if (n >= 500) miscompares++;
  endtask

  task automatic check(input string what, input logic [79:0] exp, input logic [79:0] seen);
    tests_run++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // queue a command; wf picks the waiting form
  task automatic cmd(input op_e op, input logic wf, input logic [7:0] base);
    xfer(1'b1, `HOST_CMD, {8'h00, base, 7'h00, wf, 3'h0, op});
  endtask

  // poll status until idle with nothing pending
  task automatic settle();
    int n = 0;
    do begin
      xfer(1'b0, `HOST_STAT, 32'h0000_0000);
      n++;
    end while ((rd[2] !== 1'b1 || rd[3] !== 1'b0) && n < 200);
    if (n >= 200) miscompares++;
  endtask

  task automatic mw(input int i, input logic [15:0] v);
    xfer(1'b1, 11'h400 + 11'(4 * i), {16'h0000, v});
  endtask

  // gather n image words from index i, low word first
  task automatic mr(input int i, input int n, output logic [79:0] v);
    v = 80'h0;
    for (int k = 0; k < n; k++) begin
      xfer(1'b0, 11'h400 + 11'(4 * (i + k)), 32'h0000_0000);
      v[16*k +: 16] = rd[15:0];
    end
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // watchdog far beyond the expected run
  initial begin
    repeat (50000) @(posedge sys_clk);
    miscompares++;
    wrap_up();
  end

  // main sequence
  initial begin
    repeat (20) @(posedge sys_clk);
    rst_b <= 1'b1;
    xfer(1'b0, `HOST_STAT, 32'h0000_0000);
    check("reset status", 80'h4, rd[3:0]);
    xfer(1'b0, 11'h008, 32'h0000_0000);
    check("unmapped read", 80'h0, rd);
    foreach (rows[r]) begin
      cmd(reinitialize_op, 1'b1, 8'h00);
      cmd(rows[r].first, 1'b1, 8'h00);
      cmd(rows[r].store, 1'b1, 8'h00);
      settle();
      mr(rows[r].idx, rows[r].n, got);
      check("row image", rows[r].exp, got);
    end
    // empty-stack log raises invalid, then a control load unmasks it
    mw(5, 16'h0000);
    cmd(reinitialize_op, 1'b1, 8'h00);
    cmd(scaled_log2_op, 1'b1, 8'h00);
    cmd(control_word_load_op, 1'b1, 8'h05);
    settle();
    check("irq after load", 80'h1, rd[1]);
    cmd(irq_mask_set_op, 1'b0, 8'h00);
    settle();
    check("irq masked", 80'h0, rd[1]);
    cmd(irq_mask_clear_op, 1'b0, 8'h00);
    settle();
    check("irq unmasked", 80'h1, rd[1]);
    cmd(status_word_store_op, 1'b1, 8'h10);
    settle();
    mr(16, 1, got);
    check("status flags", 80'h0081, got);
    cmd(exception_clear_op, 1'b0, 8'h00);
    settle();
    check("status after clear", 80'h0, rd[1:0]);
    // save issued while a push still runs
    cmd(reinitialize_op, 1'b1, 8'h00);
    cmd(push_ln_two_op, 1'b0, 8'h00);
    cmd(full_state_save_op, 1'b0, 8'h00);
    settle();
    mr(7, 5, got);
    check("queued save", `K_LN2, got);
    mw(96, 16'h0000);
    cmd(control_word_load_op, 1'b1, 8'h60);
    cmd(environment_store_op, 1'b1, 8'h80);
    cmd(control_word_store_op, 1'b1, 8'h90);
    settle();
    mr(130, 1, got);
    check("tag after save", 80'hFFFF, got);
    mr(144, 1, got);
    check("masks after env", 80'h003F, got);
    cmd(reinitialize_op, 1'b1, 8'h00);
    cmd(control_word_store_op, 1'b1, 8'h90);
    settle();
    mr(144, 1, got);
    check("cw after reinit", 80'h03FF, got);
    // log operations on a restored image, x on top, y below
    for (int c = 0; c < 2; c++) begin
      mw(0, 16'h03FF);
      mw(1, 16'h3000);
      mw(2, 16'h0FFF);
      for (int k = 0; k < 5; k++) begin
        mw(7 + k, xv[c][16*k +: 16]);
        mw(12 + k, yv[c][16*k +: 16]);
      end
      cmd(full_state_restore_op, 1'b1, 8'h00);
      cmd(c ? scaled_log2_plus_one_op : scaled_log2_op, 1'b1, 8'h00);
      cmd(full_state_save_op, 1'b1, 8'h00);
      settle();
      mr(7, 5, got);
      check("log result", zv[c], got);
    end
    // restored image with an unmasked exception
    mw(0, 16'h0000);
    mw(1, 16'h0001);
    cmd(full_state_restore_op, 1'b1, 8'h00);
    cmd(cpu_sync_wait, 1'b0, 8'h00);
    settle();
    check("irq after restore", 80'h1, rd[1]);
    cmd(exception_clear_op, 1'b0, 8'h00);
    settle();
    check("irq after handler", 80'h0, rd[1]);
    wrap_up();
  end
endmodule
